// ---- rtl/sfmon_pkg.sv ----
package sfmon_pkg;
	// ------------------------------------------------------------
	// fault numbers and classes
	// ------------------------------------------------------------
	localparam logic [15:0] ERR_AUTO_START_LOW = 16'h7839;
	localparam logic [15:0] ERR_MAN_START_HIGH = 16'h783a;
	localparam logic [15:0] ERR_GUARD_ACK_LONG = 16'h783b;
	localparam logic [15:0] ERR_SPEED_LIMIT = 16'h7838;
	localparam logic [15:0] ERR_MODULE_REPLACED = 16'h7834;
	localparam logic [15:0] ERR_COMMUTATION = 16'h7835;
	localparam logic [15:0] ERR_CHECKSUM = 16'h7836;
	localparam logic [15:0] ERR_BOOT_ADDR = 16'h7837;
	localparam logic [15:0] ERR_STATE_MISMATCH = 16'h783c;
	localparam logic [15:0] ERR_XF_AUX = 16'h783f;
	localparam logic [15:0] ERR_XF_INTERLOCK = 16'h7840;
	localparam logic [15:0] ERR_XF_RELAY_A = 16'h7841;
	localparam logic [2:0] CLASS_0 = 3'h0;
	localparam logic [2:0] CLASS_1 = 3'h1;
	localparam logic [2:0] CLASS_2 = 3'h2;
	localparam logic [2:0] CLASS_4 = 3'h4;
	localparam int NUM_FAULTS = 12;
	localparam int LATCH_BIT = 23;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam longint CLK_HZ = 64'hbebc200;
	localparam longint GUARD_ACK_MAX_S = 64'h6;
	localparam longint GUARD_ACK_CYCLES = GUARD_ACK_MAX_S * CLK_HZ;
	// start type encoding
	typedef enum logic [0:0] {
		START_MANUAL = 1'b0,
		START_AUTO = 1'b1
	} sfmon_start_t;
	// fault report carried out together
	typedef struct packed {
		logic [31:0] warnWord;
		logic [31:0] sigWord;
		logic [15:0] lastNumber;
		logic [2:0] lastClass;
		logic lastValid;
	} sfmon_report_t;
endpackage

// ---- rtl/sfmon_fault_monitor.sv ----
`timescale 1ns/100ps
module sfmon_fault_monitor #(
	parameter int SPEED_W = 16,
	parameter int CKSUM_W = 16,
	parameter int STATE_W = 8,
	parameter longint GUARD_ACK_LIMIT = sfmon_pkg::GUARD_ACK_CYCLES
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// start input check
	input wire logic startCheck,
	input wire logic startType,
	input wire logic safety_start_input,
	// guard door
	input wire logic guardAck,
	// speed supervision
	input wire logic autoMode,
	input wire logic [SPEED_W-1:0] velocity,
	input wire logic [SPEED_W-1:0] safely_limited_speed,
	// module and channel checks
	input wire logic moduleReplaced,
	input wire logic commutationFault,
	input wire logic [CKSUM_W-1:0] checksumA,
	input wire logic [CKSUM_W-1:0] checksumB,
	input wire logic [STATE_W-1:0] stateA,
	input wire logic [STATE_W-1:0] stateB,
	input wire logic bootInvalidWrite,
	// cross fault detection
	input wire logic auxiliary_output_one_xf,
	input wire logic interlock_output_xf,
	input wire logic relay_output_channel_a_xf,
	// latch clear
	input wire logic clearLatched,
	// results
	output logic loadDefaults,
	output sfmon_pkg::sfmon_report_t report
);
	// refuse widths and limits the logic cannot serve
	if (SPEED_W < 1 || CKSUM_W < 1 || STATE_W < 1 || GUARD_ACK_LIMIT < 1)
	begin
		$error("sfmon: bad parameter");
	end

	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rstMeta_q, rstSync_q;
	always_ff @(posedge mclk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rstMeta_q <= 1'b0;
			rstSync_q <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstSync_q <= rstMeta_q;
		end
	end
	wire logic rstN = rstSync_q;

	// ------------------------------------------------------------
	// guard acknowledge timer
	// ------------------------------------------------------------
	localparam int CW = $clog2(GUARD_ACK_LIMIT + 2);
	localparam logic [CW-1:0] ACK_LIM = CW'(GUARD_ACK_LIMIT);
	logic [CW-1:0] ackCnt_q;
	logic ackLong;
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			ackCnt_q <= '0;
		else if (!guardAck)
			ackCnt_q <= '0;
		else if (ackCnt_q <= ACK_LIM)
			ackCnt_q <= ackCnt_q + CW'(1);
	end
	assign ackLong = guardAck && (ackCnt_q == ACK_LIM);

	// ------------------------------------------------------------
	// fault conditions
	// ------------------------------------------------------------
	logic [sfmon_pkg::NUM_FAULTS-1:0] evt;
	logic [sfmon_pkg::NUM_FAULTS-1:0] evtPrev_q;
	logic [sfmon_pkg::NUM_FAULTS-1:0] rise;
	always_comb
	begin
		evt[0] = startCheck && startType == sfmon_pkg::START_AUTO && !safety_start_input;
		evt[1] = startCheck && startType == sfmon_pkg::START_MANUAL && safety_start_input;
		evt[2] = ackLong;
		evt[3] = autoMode && (velocity > safely_limited_speed);
		evt[4] = moduleReplaced;
		evt[5] = commutationFault;
		evt[6] = checksumA != checksumB;
		evt[7] = bootInvalidWrite;
		evt[8] = stateA != stateB;
		evt[9] = auxiliary_output_one_xf;
		evt[10] = interlock_output_xf;
		evt[11] = relay_output_channel_a_xf;
	end

	// edge detect so a persisting condition reports once
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			evtPrev_q <= '0;
		else
			evtPrev_q <= evt;
	end
	assign rise = evt & ~evtPrev_q;

	// number and class table
	function automatic logic [18:0] faultInfo(input int idx);
		case (idx)
			0: faultInfo = {sfmon_pkg::ERR_AUTO_START_LOW, sfmon_pkg::CLASS_2};
			1: faultInfo = {sfmon_pkg::ERR_MAN_START_HIGH, sfmon_pkg::CLASS_2};
			2: faultInfo = {sfmon_pkg::ERR_GUARD_ACK_LONG, sfmon_pkg::CLASS_2};
			3: faultInfo = {sfmon_pkg::ERR_SPEED_LIMIT, sfmon_pkg::CLASS_1};
			4: faultInfo = {sfmon_pkg::ERR_MODULE_REPLACED, sfmon_pkg::CLASS_0};
			5: faultInfo = {sfmon_pkg::ERR_COMMUTATION, sfmon_pkg::CLASS_4};
			6: faultInfo = {sfmon_pkg::ERR_CHECKSUM, sfmon_pkg::CLASS_4};
			7: faultInfo = {sfmon_pkg::ERR_BOOT_ADDR, sfmon_pkg::CLASS_0};
			8: faultInfo = {sfmon_pkg::ERR_STATE_MISMATCH, sfmon_pkg::CLASS_4};
			9: faultInfo = {sfmon_pkg::ERR_XF_AUX, sfmon_pkg::CLASS_2};
			10: faultInfo = {sfmon_pkg::ERR_XF_INTERLOCK, sfmon_pkg::CLASS_2};
			default: faultInfo = {sfmon_pkg::ERR_XF_RELAY_A, sfmon_pkg::CLASS_2};
		endcase
	endfunction

	// split new events by class
	logic anyWarn, anySig;
	logic [18:0] newest;
	logic [18:0] info;
	logic newestValid;
	always_comb
	begin
		anyWarn = 1'b0;
		anySig = 1'b0;
		newest = '0;
		info = '0;
		newestValid = 1'b0;
		for (int i = 0; i < sfmon_pkg::NUM_FAULTS; i++)
		begin
			info = faultInfo(i);
			if (rise[i])
			begin
				if (info[2:0] == sfmon_pkg::CLASS_0)
					anyWarn = 1'b1;
				else
					anySig = 1'b1;
				if (!newestValid)
				begin
					newest = info;
					newestValid = 1'b1;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// latched words
	// ------------------------------------------------------------
	logic warnBit_q, sigBit_q;
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			warnBit_q <= 1'b0;
		else if (anyWarn)
			warnBit_q <= 1'b1;
		else if (clearLatched)
			warnBit_q <= 1'b0;
	end
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			sigBit_q <= 1'b0;
		else if (anySig)
			sigBit_q <= 1'b1;
		else if (clearLatched)
			sigBit_q <= 1'b0;
	end

	// ------------------------------------------------------------
	// last fault record
	// ------------------------------------------------------------
	logic [15:0] lastNum_q;
	logic [2:0] lastCls_q;
	logic lastValid_q;
	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
		begin
			lastNum_q <= '0;
			lastCls_q <= '0;
			lastValid_q <= 1'b0;
		end
		else if (newestValid)
		begin
			lastNum_q <= newest[18:3];
			lastCls_q <= newest[2:0];
			lastValid_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk or negedge rstN)
	begin
		if (!rstN)
			loadDefaults <= 1'b0;
		else
			loadDefaults <= rise[4];
	end

	// report assembly
	always_comb
	begin
		report = '0;
		report.warnWord[sfmon_pkg::LATCH_BIT] = warnBit_q;
		report.sigWord[sfmon_pkg::LATCH_BIT] = sigBit_q;
		report.lastNumber = lastNum_q;
		report.lastClass = lastCls_q;
		report.lastValid = lastValid_q;
	end
endmodule

// ---- sim/sfmon_checker.sv ----
`timescale 1ns/100ps
module sfmon_checker #(
	parameter int SPEED_W = 16,
	parameter int CKSUM_W = 16,
	parameter int STATE_W = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// fault sources
	input wire logic startCheck,
	input wire logic startType,
	input wire logic safety_start_input,
	input wire logic autoMode,
	input wire logic [SPEED_W-1:0] velocity,
	input wire logic [SPEED_W-1:0] safely_limited_speed,
	input wire logic moduleReplaced,
	input wire logic commutationFault,
	input wire logic [CKSUM_W-1:0] checksumA,
	input wire logic [CKSUM_W-1:0] checksumB,
	input wire logic [STATE_W-1:0] stateA,
	input wire logic [STATE_W-1:0] stateB,
	input wire logic bootInvalidWrite,
	input wire logic auxiliary_output_one_xf,
	input wire logic interlock_output_xf,
	input wire logic relay_output_channel_a_xf,
	input wire logic clearLatched,
	// results
	input wire logic loadDefaults,
	input wire sfmon_pkg::sfmon_report_t report
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// ------------------------------------------------
	// event sequences
	// ------------------------------------------------
	sequence s_warnEv;
		$rose(moduleReplaced) || $rose(bootInvalidWrite);
	endsequence
	sequence s_pulse;
		loadDefaults ##1 !loadDefaults;
	endsequence
	a_start_level: assert property ($rose(startCheck && (startType ^ safety_start_input))
		|=> report.sigWord[23]) else $error("start level fault missed");
	a_speed_limit: assert property ($rose(autoMode && velocity > safely_limited_speed)
		|=> report.sigWord[23]) else $error("speed fault missed");
	a_warn_set: assert property (s_warnEv |=> report.warnWord[23])
		else $error("warning bit missed");
	a_defaults_pulse: assert property ($rose(moduleReplaced) |=> s_pulse)
		else $error("defaults pulse wrong");
	a_commut_fault: assert property ($rose(commutationFault) |=> report.sigWord[23])
		else $error("commutation fault missed");
	a_cksum_diff: assert property ($rose(checksumA != checksumB) |=> report.sigWord[23])
		else $error("checksum fault missed");
	a_state_diff: assert property ($rose(stateA != stateB) |=> report.sigWord[23])
		else $error("state fault missed");
	a_cross_fault: assert property ($rose(auxiliary_output_one_xf || interlock_output_xf
		|| relay_output_channel_a_xf) |=> report.sigWord[23]) else $error("cross fault missed");
	a_latch_hold: assert property (report.sigWord[23] && !clearLatched |=> report.sigWord[23])
		else $error("signal bit dropped");
	a_warn_hold: assert property (report.warnWord[23] && !clearLatched
		|=> report.warnWord[23]) else $error("warning bit dropped");
	a_valid_hold: assert property (report.lastValid |=> report.lastValid)
		else $error("fault record dropped");
endmodule
bind sfmon_fault_monitor sfmon_checker #(.SPEED_W(SPEED_W), .CKSUM_W(CKSUM_W),
	.STATE_W(STATE_W)) u_chk (.mclk(mclk), .reset_n(reset_n), .startCheck(startCheck),
	.startType(startType), .safety_start_input(safety_start_input), .autoMode(autoMode),
	.velocity(velocity), .safely_limited_speed(safely_limited_speed),
	.moduleReplaced(moduleReplaced), .commutationFault(commutationFault),
	.checksumA(checksumA), .checksumB(checksumB), .stateA(stateA), .stateB(stateB),
	.bootInvalidWrite(bootInvalidWrite), .auxiliary_output_one_xf(auxiliary_output_one_xf),
	.interlock_output_xf(interlock_output_xf),
	.relay_output_channel_a_xf(relay_output_channel_a_xf), .clearLatched(clearLatched),
	.loadDefaults(loadDefaults), .report(report));

// ---- sim/sfmon_wiring_model.sv ----
`timescale 1ns/100ps
module sfmon_wiring_model (
	// bench commands
	input wire logic startHigh,
	input wire logic ackReq,
	input wire logic [2:0] xfReq,
	// wiring seen by the monitor
	output logic safety_start_input,
	output logic guardAck,
	output logic [2:0] xfFlag
);
	// start input and shorted outputs follow the bench
	assign safety_start_input = startHigh;
	assign xfFlag = xfReq;
	assign guardAck = ackReq;
endmodule

// ---- sim/sfmon_fault_monitor_tb_top.sv ----
`timescale 1ns/100ps
module sfmon_fault_monitor_tb_top;
	localparam int LIM = 20;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [11:0] ev = 12'h0;
	logic clearLatched = 1'b0;
	logic loadDefaults, guardAck, startIn;
	logic [2:0] xf;
	sfmon_pkg::sfmon_report_t report;
	int errors = 0;
	int check_count = 0;
	logic [15:0] num [12] = '{16'h7839, 16'h783a, 16'h783b, 16'h7838, 16'h7834, 16'h7835,
		16'h7836, 16'h7837, 16'h783c, 16'h783f, 16'h7840, 16'h7841};
	logic [2:0] cls [12] = '{3'h2, 3'h2, 3'h2, 3'h1, 3'h0, 3'h4, 3'h4, 3'h0, 3'h4, 3'h2,
		3'h2, 3'h2};
	// clock
	always #2.5 mclk = ~mclk;
	// far side wiring and monitor
	sfmon_wiring_model u_wire (.startHigh(ev[1]), .ackReq(ev[2]), .xfReq(ev[11:9]),
		.safety_start_input(startIn), .guardAck(guardAck), .xfFlag(xf));
	sfmon_fault_monitor #(.GUARD_ACK_LIMIT(LIM)) DUT (.mclk(mclk), .reset_n(reset_n),
		.startCheck(ev[0] | ev[1]), .startType(ev[0]), .safety_start_input(startIn),
		.guardAck(guardAck), .autoMode(1'b1), .velocity({15'h0080, ev[3]}),
		.safely_limited_speed(16'h0100), .moduleReplaced(ev[4]), .commutationFault(ev[5]),
		.checksumA(16'h5a5a), .checksumB({15'h2d2d, ev[6]}), .stateA(8'h3c),
		.stateB({7'h1e, ev[8]}), .bootInvalidWrite(ev[7]), .auxiliary_output_one_xf(xf[0]),
		.interlock_output_xf(xf[1]), .relay_output_channel_a_xf(xf[2]),
		.clearLatched(clearLatched), .loadDefaults(loadDefaults), .report(report));
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	task idle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task give_verdict;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// quiet inputs, speed at its limit
	task t_idle;
		chk("idle bits", 16'h0, 16'({report.warnWord[23], report.sigWord[23]}));
		chk("idle valid", 16'h0, 16'(report.lastValid));
	endtask
	// each source alone, then clear while still active
	task t_faults;
		for (int i = 0; i < 12; i++)
		begin
			@(posedge mclk) ev <= 12'h1 << i;
			idle(1);
			chk("defaults pulse", 16'(i == 4), 16'(loadDefaults));
			idle(1);
			chk("defaults end", 16'h0, 16'(loadDefaults));
			if (i == 2)
				idle(LIM + 2);
			chk("number", num[i], report.lastNumber);
			chk("class", 16'(cls[i]), 16'(report.lastClass));
			chk("valid", 16'h1, 16'(report.lastValid));
			chk("warn bit", 16'(cls[i] == 3'h0), 16'(report.warnWord[23]));
			chk("signal bit", 16'(cls[i] != 3'h0), 16'(report.sigWord[23]));
			@(posedge mclk) clearLatched <= 1'b1;
			@(posedge mclk) clearLatched <= 1'b0;
			idle(2);
			chk("held bits", 16'h0, 16'({report.warnWord[23], report.sigWord[23]}));
			chk("kept number", num[i], report.lastNumber);
			@(posedge mclk) ev <= 12'h0;
			idle(2);
		end
	endtask
	// acknowledge held exactly the limit, then one cycle more
	task t_guard_short;
		@(posedge mclk) ev <= 12'h4;
		repeat (LIM - 1) @(posedge mclk);
		@(posedge mclk) ev <= 12'h0;
		idle(LIM);
		chk("short ack bit", 16'h0, 16'(report.sigWord[23]));
		@(posedge mclk) ev <= 12'h4;
		repeat (LIM) @(posedge mclk);
		@(posedge mclk) ev <= 12'h0;
		idle(2);
		chk("long ack bit", 16'h1, 16'(report.sigWord[23]));
	endtask
	// checksum and state faults together
	task t_order;
		@(posedge mclk) ev <= 12'h140;
		idle(2);
		chk("order number", 16'h7836, report.lastNumber);
		@(posedge mclk) ev <= 12'h0;
		idle(2);
	endtask
	// main sequence
	initial
	begin
		repeat (5) @(posedge mclk);
		reset_n <= 1'b1;
		idle(3);
		t_idle;
		t_faults;
		t_guard_short;
		t_order;
		give_verdict;
	end
	// watchdog
	initial
	begin
		repeat (5000) @(posedge mclk);
		errors++;
		give_verdict;
	end
endmodule
